//--- design/scr_pkg.sv
// Constants and carriers of the serial-control and timebase register bank.
// Assumes a serial engine turning frames into byte requests on sys_clk.
package scr_pkg;

    // ==================================================================
    // Register offsets
    localparam logic [15:0] OFS_SERIAL_CTRL = 16'h0000;
    localparam logic [15:0] OFS_READBACK_SEL = 16'h0004;
    localparam logic [15:0] OFS_XFER_STROBE = 16'h0005;
    localparam logic [15:0] OFS_SCRATCH_LO = 16'h0006;
    localparam logic [15:0] OFS_SCRATCH_HI = 16'h0007;
    localparam logic [15:0] OFS_DIE_REV = 16'h000A;
    localparam logic [15:0] OFS_ID_PAD = 16'h000B;
    localparam logic [15:0] OFS_FAMILY_LO = 16'h000C;
    localparam logic [15:0] OFS_FAMILY_HI = 16'h000D;
    localparam logic [15:0] OFS_TB_NDIV = 16'h0100;
    localparam logic [15:0] OFS_TB_OPTS = 16'h0101;
    localparam logic [15:0] OFS_TB_RSVD = 16'h0102;
    localparam logic [15:0] OFS_TB_PER_LO = 16'h0103;
    localparam logic [15:0] OFS_TB_PER_MID = 16'h0104;
    localparam logic [15:0] OFS_TB_PER_HI = 16'h0105;
    localparam logic [15:0] OFS_TB_SETTLE_LO = 16'h0106;
    localparam logic [15:0] OFS_TB_SETTLE_MID = 16'h0107;
    localparam logic [15:0] OFS_TB_SETTLE_HI = 16'h0108;

    // ==================================================================
    // Field positions
    localparam int BIT_SERIAL_OUT_DRIVE = 7;
    localparam int BIT_LSB_FIRST = 6;
    localparam int BIT_SOFT_RESET = 5;
    localparam int BIT_READBACK_STAGED = 0;
    localparam int BIT_XFER = 0;
    localparam int BIT_ROM_LOAD = 4;
    localparam int BIT_SETTLE_RESTART = 4;
    localparam int OPTS_W = 4;
    localparam int PER_HI_W = 5;
    localparam int SETTLE_HI_W = 4;

    // ==================================================================
    // Values after reset
    localparam logic [7:0] RST_SERIAL_CTRL = 8'h00;
    localparam logic [0:0] RST_READBACK_SEL = 1'h0;
    localparam logic [15:0] RST_SCRATCH = 16'h0000;
    localparam logic [7:0] RST_TB_NDIV = 8'h08;
    localparam logic [OPTS_W-1:0] RST_TB_OPTS = 4'h9;
    localparam logic [7:0] RST_TB_PER_LO = 8'h0E;
    localparam logic [7:0] RST_TB_PER_MID = 8'h67;
    localparam logic [PER_HI_W-1:0] RST_TB_PER_HI = 5'h13;
    localparam logic [7:0] RST_TB_SETTLE_LO = 8'h32;
    localparam logic [7:0] RST_TB_SETTLE_MID = 8'h00;
    localparam logic [SETTLE_HI_W-1:0] RST_TB_SETTLE_HI = 4'h0;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scr_bus_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic wr;
    } scr_ee_req_t;

    typedef struct packed {
        logic [7:0] n_div;
        logic crystal_oscillator_select;
        logic [1:0] p_div;
        logic doubler_en;
        logic [20:0] period_fs;
        logic [19:0] settle_ms;
    } scr_timebase_cfg_t;

endpackage

//--- design/scr_stage_reg.sv
// Buffered register: staged copy written by host, active copy on strobe.
// Assumes commit, write and load strobes are one-cycle pulses.
`timescale 1ns/1ns
module scr_stage_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    input wire logic ee_en,
    input wire logic [W-1:0] ee_data,
    input wire logic commit,
    output logic [W-1:0] staged_q,
    output logic [W-1:0] active_q
);

    logic [W-1:0] staged_d, active_d;

    always_comb begin
        staged_d = staged_q;
        active_d = active_q;
        if (wr_en) begin
            staged_d = wdata;
        end else if (ee_en) begin
            staged_d = ee_data;
        end
        // Active copy only moves on the strobe
        if (commit) begin
            active_d = staged_q; // R9
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            staged_q <= RST;
            active_q <= RST;
        end else begin
            staged_q <= staged_d;
            active_q <= active_d;
        end
    end

endmodule // scr_stage_reg

//--- design/scr_regs.sv
// Serial-control, identification and reference-timebase register bank.
// Assumes one byte request per cycle from the serial engine or EEPROM.
//
// What this block does
// [R1] Writes to unlisted addresses change nothing; reads of them return zero.
// [R2] Host writes reserved fields with their defaults; bank stores none.
// [R3] Read-only registers return current value and ignore all writes.
// [R4] Autoclear bits drop to zero by themselves once their action fires.
// [R5] EEPROM restore skips excluded registers, keeping their present value.
// [R6] Live registers act on write at once; live status reads current.
// [R7] Sixteen-bit family identifier, low byte first, high byte next address.
// [R8] Nominal timebase period is 21 bits of femtoseconds over three bytes.
// [R9] Transfer strobe copies all buffered settings to active, then clears.
// [R10] Soft reset restores defaults except protected bits, then clears.
`timescale 1ns/1ns
module scr_regs #(
    // Identification values are arbitrary
    parameter logic [7:0] DIE_REVISION = 8'h5A,
    parameter logic [15:0] FAMILY_ID = 16'hC3A5
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire scr_pkg::scr_bus_req_t bus_req,
    input wire scr_pkg::scr_ee_req_t ee_req,
    input wire logic rom_load_status,
    output logic [7:0] bus_rdata,
    output logic bus_rvalid,
    output logic serial_out_drive_enable,
    output logic lsb_first,
    output logic [15:0] scratch,
    output scr_pkg::scr_timebase_cfg_t timebase_cfg,
    output logic settle_timer_restart
);

    // ==================================================================
    // Address decode
    logic hit_serial, hit_rbsel, hit_xfer, hit_scr_lo, hit_scr_hi;
    logic hit_ndiv, hit_opts, hit_per_lo, hit_per_mid, hit_per_hi;
    logic hit_set_lo, hit_set_mid, hit_set_hi;
    logic wr_go, ee_go;

    always_comb begin
        hit_serial = (bus_req.addr == scr_pkg::OFS_SERIAL_CTRL);
        hit_rbsel = (bus_req.addr == scr_pkg::OFS_READBACK_SEL);
        hit_xfer = (bus_req.addr == scr_pkg::OFS_XFER_STROBE);
        hit_scr_lo = (bus_req.addr == scr_pkg::OFS_SCRATCH_LO);
        hit_scr_hi = (bus_req.addr == scr_pkg::OFS_SCRATCH_HI);
        hit_ndiv = (bus_req.addr == scr_pkg::OFS_TB_NDIV);
        hit_opts = (bus_req.addr == scr_pkg::OFS_TB_OPTS);
        hit_per_lo = (bus_req.addr == scr_pkg::OFS_TB_PER_LO);
        hit_per_mid = (bus_req.addr == scr_pkg::OFS_TB_PER_MID);
        hit_per_hi = (bus_req.addr == scr_pkg::OFS_TB_PER_HI);
        hit_set_lo = (bus_req.addr == scr_pkg::OFS_TB_SETTLE_LO);
        hit_set_mid = (bus_req.addr == scr_pkg::OFS_TB_SETTLE_MID);
        hit_set_hi = (bus_req.addr == scr_pkg::OFS_TB_SETTLE_HI);
        wr_go = bus_req.wr;
        ee_go = ee_req.wr & ~bus_req.wr;
    end

    // ==================================================================
    // Live control: serial port, strobes, scratch pad
    logic soft_q, soft_d;
    logic commit_q, commit_d;
    logic drive_q, drive_d;
    logic lsbf_q, lsbf_d;
    logic [15:0] scr_q, scr_d;
    logic settle_stage_q, settle_stage_d;
    logic restart_q, restart_d;

    always_comb begin
        soft_d = 1'b0; // R4 R10
        commit_d = 1'b0; // R4 R9
        drive_d = drive_q;
        lsbf_d = lsbf_q;
        scr_d = scr_q;
        settle_stage_d = settle_stage_q;
        restart_d = 1'b0;
        if (wr_go && hit_serial) begin
            drive_d = bus_req.wdata[scr_pkg::BIT_SERIAL_OUT_DRIVE]; // R6
            lsbf_d = bus_req.wdata[scr_pkg::BIT_LSB_FIRST];
            soft_d = bus_req.wdata[scr_pkg::BIT_SOFT_RESET]; // R10
        end else if (wr_go && hit_xfer) begin
            commit_d = bus_req.wdata[scr_pkg::BIT_XFER]; // R9
        end else if (wr_go && hit_scr_lo) begin
            scr_d[7:0] = bus_req.wdata; // R6
        end else if (wr_go && hit_scr_hi) begin
            scr_d[15:8] = bus_req.wdata; // R6
        end else if (wr_go && hit_set_hi) begin
            settle_stage_d = bus_req.wdata[scr_pkg::BIT_SETTLE_RESTART];
        end
        // Serial control is excluded from EEPROM restore
        if (ee_go && ee_req.addr == scr_pkg::OFS_SCRATCH_LO) begin
            scr_d[7:0] = ee_req.data; // R5
        end else if (ee_go && ee_req.addr == scr_pkg::OFS_SCRATCH_HI) begin
            scr_d[15:8] = ee_req.data;
        end
        // Restart request fires on the strobe and then clears itself
        if (commit_q && settle_stage_q) begin
            restart_d = 1'b1;
            settle_stage_d = settle_stage_d & wr_go & hit_set_hi; // R4
        end
        // Soft reset: scratch and staged bits to default, port bits kept
        if (soft_q) begin
            scr_d = scr_pkg::RST_SCRATCH; // R10
            settle_stage_d = 1'b0;
            commit_d = 1'b0;
            restart_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            soft_q <= 1'b0;
            commit_q <= 1'b0;
            drive_q <= scr_pkg::RST_SERIAL_CTRL[scr_pkg::BIT_SERIAL_OUT_DRIVE];
            lsbf_q <= scr_pkg::RST_SERIAL_CTRL[scr_pkg::BIT_LSB_FIRST];
            scr_q <= scr_pkg::RST_SCRATCH;
            settle_stage_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            soft_q <= soft_d;
            commit_q <= commit_d;
            drive_q <= drive_d;
            lsbf_q <= lsbf_d;
            scr_q <= scr_d;
            settle_stage_q <= settle_stage_d;
            restart_q <= restart_d;
        end
    end

    // ==================================================================
    // Buffered registers
    logic bank_rst;
    logic rb_stg, rb_act;
    logic [7:0] ndiv_stg, ndiv_act;
    logic [scr_pkg::OPTS_W-1:0] opts_stg, opts_act;
    logic [7:0] perl_stg, perl_act, perm_stg, perm_act;
    logic [scr_pkg::PER_HI_W-1:0] perh_stg, perh_act;
    logic [7:0] setl_stg, setl_act, setm_stg, setm_act;
    logic [scr_pkg::SETTLE_HI_W-1:0] seth_stg, seth_act;

    always_comb begin
        bank_rst = sys_rst | soft_q; // R10
    end

    scr_stage_reg #(.W(1), .RST(scr_pkg::RST_READBACK_SEL)) u_rbsel (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_rbsel),
        .wdata(bus_req.wdata[scr_pkg::BIT_READBACK_STAGED]),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_READBACK_SEL)),
        .ee_data(ee_req.data[scr_pkg::BIT_READBACK_STAGED]),
        .staged_q(rb_stg), .active_q(rb_act));

    scr_stage_reg #(.W(8), .RST(scr_pkg::RST_TB_NDIV)) u_ndiv (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_ndiv), .wdata(bus_req.wdata),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_NDIV)),
        .ee_data(ee_req.data), .staged_q(ndiv_stg), .active_q(ndiv_act));

    // Load-from-ROM bit is read-only and not stored here
    scr_stage_reg #(.W(scr_pkg::OPTS_W), .RST(scr_pkg::RST_TB_OPTS)) u_opts (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_opts),
        .wdata(bus_req.wdata[scr_pkg::OPTS_W-1:0]), // R3
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_OPTS)),
        .ee_data(ee_req.data[scr_pkg::OPTS_W-1:0]),
        .staged_q(opts_stg), .active_q(opts_act));

    scr_stage_reg #(.W(8), .RST(scr_pkg::RST_TB_PER_LO)) u_perl (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_per_lo), .wdata(bus_req.wdata),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_PER_LO)),
        .ee_data(ee_req.data), .staged_q(perl_stg), .active_q(perl_act));

    scr_stage_reg #(.W(8), .RST(scr_pkg::RST_TB_PER_MID)) u_perm (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_per_mid), .wdata(bus_req.wdata),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_PER_MID)),
        .ee_data(ee_req.data), .staged_q(perm_stg), .active_q(perm_act));

    scr_stage_reg #(.W(scr_pkg::PER_HI_W), .RST(scr_pkg::RST_TB_PER_HI))
    u_perh (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_per_hi),
        .wdata(bus_req.wdata[scr_pkg::PER_HI_W-1:0]), // R8
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_PER_HI)),
        .ee_data(ee_req.data[scr_pkg::PER_HI_W-1:0]),
        .staged_q(perh_stg), .active_q(perh_act));

    scr_stage_reg #(.W(8), .RST(scr_pkg::RST_TB_SETTLE_LO)) u_setl (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_set_lo), .wdata(bus_req.wdata),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_SETTLE_LO)),
        .ee_data(ee_req.data), .staged_q(setl_stg), .active_q(setl_act));

    scr_stage_reg #(.W(8), .RST(scr_pkg::RST_TB_SETTLE_MID)) u_setm (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_set_mid), .wdata(bus_req.wdata),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_SETTLE_MID)),
        .ee_data(ee_req.data), .staged_q(setm_stg), .active_q(setm_act));

    scr_stage_reg #(.W(scr_pkg::SETTLE_HI_W), .RST(scr_pkg::RST_TB_SETTLE_HI))
    u_seth (
        .clk(sys_clk), .rst(bank_rst), .commit(commit_q),
        .wr_en(wr_go & hit_set_hi),
        .wdata(bus_req.wdata[scr_pkg::SETTLE_HI_W-1:0]),
        .ee_en(ee_go & (ee_req.addr == scr_pkg::OFS_TB_SETTLE_HI)),
        .ee_data(ee_req.data[scr_pkg::SETTLE_HI_W-1:0]),
        .staged_q(seth_stg), .active_q(seth_act));

    // ==================================================================
    // Readback
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic rb;

    always_comb begin
        rb = rb_act;
        rdata_d = rdata_q;
        rvalid_d = bus_req.rd;
        if (bus_req.rd) begin
            rdata_d = 8'h00; // R1
            if (hit_serial) begin
                rdata_d[scr_pkg::BIT_SERIAL_OUT_DRIVE] = drive_q;
                rdata_d[scr_pkg::BIT_LSB_FIRST] = lsbf_q;
                rdata_d[scr_pkg::BIT_SOFT_RESET] = soft_q;
            end else if (hit_rbsel) begin
                rdata_d[scr_pkg::BIT_READBACK_STAGED] = rb ? rb_stg : rb_act;
            end else if (hit_xfer) begin
                rdata_d[scr_pkg::BIT_XFER] = commit_q;
            end else if (hit_scr_lo) begin
                rdata_d = scr_q[7:0];
            end else if (hit_scr_hi) begin
                rdata_d = scr_q[15:8];
            end else if (bus_req.addr == scr_pkg::OFS_DIE_REV) begin
                rdata_d = DIE_REVISION; // R3
            end else if (bus_req.addr == scr_pkg::OFS_FAMILY_LO) begin
                rdata_d = FAMILY_ID[7:0]; // R7
            end else if (bus_req.addr == scr_pkg::OFS_FAMILY_HI) begin
                rdata_d = FAMILY_ID[15:8]; // R7
            end else if (hit_ndiv) begin
                rdata_d = rb ? ndiv_stg : ndiv_act;
            end else if (hit_opts) begin
                rdata_d[scr_pkg::OPTS_W-1:0] = rb ? opts_stg : opts_act;
                rdata_d[scr_pkg::BIT_ROM_LOAD] = rom_load_status; // R6
            end else if (hit_per_lo) begin
                rdata_d = rb ? perl_stg : perl_act;
            end else if (hit_per_mid) begin
                rdata_d = rb ? perm_stg : perm_act;
            end else if (hit_per_hi) begin
                rdata_d[scr_pkg::PER_HI_W-1:0] = rb ? perh_stg : perh_act;
            end else if (hit_set_lo) begin
                rdata_d = rb ? setl_stg : setl_act;
            end else if (hit_set_mid) begin
                rdata_d = rb ? setm_stg : setm_act;
            end else if (hit_set_hi) begin
                rdata_d[scr_pkg::SETTLE_HI_W-1:0] = rb ? seth_stg : seth_act;
                rdata_d[scr_pkg::BIT_SETTLE_RESTART] = settle_stage_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ==================================================================
    // Outputs
    always_comb begin
        bus_rdata = rdata_q;
        bus_rvalid = rvalid_q;
        serial_out_drive_enable = drive_q;
        lsb_first = lsbf_q;
        scratch = scr_q;
        settle_timer_restart = restart_q;
        timebase_cfg.n_div = ndiv_act;
        timebase_cfg.crystal_oscillator_select = opts_act[3];
        timebase_cfg.p_div = opts_act[2:1];
        timebase_cfg.doubler_en = opts_act[0];
        timebase_cfg.period_fs = {perh_act, perm_act, perl_act}; // R8
        timebase_cfg.settle_ms = {seth_act, setm_act, setl_act};
    end

endmodule // scr_regs

//--- testbench/scr_host_model.sv
// Host model: replays queued byte requests to the register bank.
// Assumes the bank takes requests on the rising edge of sys_clk.
`timescale 1ns/1ns
module scr_host_model (
    input wire logic sys_clk,
    output scr_pkg::scr_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rvalid
);
    scr_pkg::scr_bus_req_t cmd_q[$];
    logic [7:0] rsp_q[$];
    // ==================================================================
    // Requests change at the falling edge; idle fields keep toggling
    always @(negedge sys_clk) begin
        if (cmd_q.size() > 0) begin
            bus_req <= cmd_q.pop_front();
        end else begin
            bus_req <= {~bus_req.addr, ~bus_req.wdata, 2'b00};
        end
    end
    always @(posedge sys_clk) begin
        if (bus_rvalid) begin
            rsp_q.push_back(bus_rdata);
        end
    end
endmodule // scr_host_model

//--- testbench/scr_regs_sva.sv
// Checker for the register bank, sees only its top-level ports.
// Assumes the bind below attaches it to every scr_regs instance.
`timescale 1ns/1ns
module scr_regs_sva #(
    parameter logic [7:0] DIE_REVISION = 8'h5A,
    parameter logic [15:0] FAMILY_ID = 16'hC3A5
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire scr_pkg::scr_bus_req_t bus_req,
    input wire scr_pkg::scr_ee_req_t ee_req,
    input wire logic rom_load_status,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic serial_out_drive_enable,
    input wire logic lsb_first,
    input wire logic [15:0] scratch,
    input wire scr_pkg::scr_timebase_cfg_t timebase_cfg,
    input wire logic settle_timer_restart
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ==================================================================
    // Read path
    rd_answer_a: assert property (bus_req.rd |=> bus_rvalid)
        else $error("read not answered");
    rev_value_a: assert property (bus_req.rd &&
        bus_req.addr == scr_pkg::OFS_DIE_REV |=> bus_rdata == DIE_REVISION)
        else $error("revision read wrong");
    family_low_a: assert property (bus_req.rd &&
        bus_req.addr == scr_pkg::OFS_FAMILY_LO |=> bus_rdata == FAMILY_ID[7:0])
        else $error("family low byte wrong");
    family_high_a: assert property (bus_req.rd &&
        bus_req.addr == scr_pkg::OFS_FAMILY_HI |=> bus_rdata == FAMILY_ID[15:8])
        else $error("family high byte wrong");
    unlisted_zero_a: assert property (bus_req.rd &&
        bus_req.addr == 16'h0009 |=> bus_rdata == 8'h00)
        else $error("unlisted read not zero");
    rom_status_a: assert property (bus_req.rd &&
        bus_req.addr == scr_pkg::OFS_TB_OPTS |=>
        bus_rdata[4] == $past(rom_load_status))
        else $error("load status bit stale");
    // ==================================================================
    // Live, autoclear and reset effects
    scratch_live_a: assert property (bus_req.wr &&
        bus_req.addr == scr_pkg::OFS_SCRATCH_LO |=>
        scratch[7:0] == $past(bus_req.wdata))
        else $error("scratch not live");
    strobe_clear_a: assert property ((bus_req.wr && bus_req.wdata[0] &&
        bus_req.addr == scr_pkg::OFS_XFER_STROBE) ##2 (bus_req.rd &&
        bus_req.addr == scr_pkg::OFS_XFER_STROBE) |=> bus_rdata == 8'h00)
        else $error("strobe bit did not clear");
    restart_fire_a: assert property ((bus_req.wr && bus_req.wdata[4] &&
        bus_req.addr == scr_pkg::OFS_TB_SETTLE_HI) ##1 (bus_req.wr &&
        bus_req.wdata[0] && bus_req.addr == scr_pkg::OFS_XFER_STROBE)
        |=> ##1 settle_timer_restart)
        else $error("restart did not fire");
    restart_pulse_a: assert property (settle_timer_restart |=>
        !settle_timer_restart)
        else $error("restart longer than one cycle");
    soft_reset_a: assert property (bus_req.wr && bus_req.wdata[5] &&
        bus_req.addr == scr_pkg::OFS_SERIAL_CTRL |=> ##1 scratch == 16'h0000)
        else $error("soft reset left scratch");
endmodule // scr_regs_sva

bind scr_regs scr_regs_sva #(.DIE_REVISION(DIE_REVISION),
    .FAMILY_ID(FAMILY_ID)) u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .ee_req(ee_req), .rom_load_status(rom_load_status),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .serial_out_drive_enable(serial_out_drive_enable),
    .lsb_first(lsb_first), .scratch(scratch), .timebase_cfg(timebase_cfg),
    .settle_timer_restart(settle_timer_restart));

//--- testbench/testbench.sv
// Self-checking bench for the register bank with a queue-based host.
// Assumes scr_pkg, scr_regs and scr_host_model are compiled first.
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary value
    localparam logic [15:0] FAM = 16'h9617; // Arbitrary value
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    scr_pkg::scr_bus_req_t bus_req;
    scr_pkg::scr_ee_req_t ee_req = '0;
    logic rom_load_status = 1'b0;
    logic [7:0] bus_rdata;
    logic bus_rvalid, serial_out_drive_enable, lsb_first, settle_timer_restart;
    logic [15:0] scratch;
    scr_pkg::scr_timebase_cfg_t timebase_cfg;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 36303;
    int pulses = 0;
    logic [7:0] stg[9], act[9];
    logic [7:0] msk[9] = '{8'hFF, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'h1F, 8'hFF,
        8'hFF, 8'h0F};
    logic [7:0] dflt[9] = '{8'h08, 8'h09, 8'h00, 8'h0E, 8'h67, 8'h13, 8'h32,
        8'h00, 8'h00};
    logic [7:0] ctl = 8'h00;
    logic [15:0] scr = 16'h0000;
    logic rb_stg = 1'b0, rb_act = 1'b0;
    logic [15:0] ro[7] = '{16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h0001,
        16'h0009, 16'h0109};

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) pulses += int'(settle_timer_restart === 1'b1);

    scr_host_model host (.sys_clk(sys_clk), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
    scr_regs #(.DIE_REVISION(REV), .FAMILY_ID(FAM)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .ee_req(ee_req), .rom_load_status(rom_load_status),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .serial_out_drive_enable(serial_out_drive_enable),
        .lsb_first(lsb_first), .scratch(scratch),
        .timebase_cfg(timebase_cfg),
        .settle_timer_restart(settle_timer_restart));

    // ==================================================================
    // Reporting
    task automatic check(string name, logic [63:0] got, logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==================================================================
    // Model and bus tasks
    function automatic logic [7:0] exp_rd(logic [15:0] a);
        logic [7:0] v[9];
        v = act;
        if (rb_act) v = stg;
        v[1][4] = rom_load_status;
        case (a)
            16'h0000: return ctl;
            16'h0006: return scr[7:0];
            16'h0007: return scr[15:8];
            16'h000A: return REV;
            16'h000C: return FAM[7:0];
            16'h000D: return FAM[15:8];
            default: return (a >= 16'h0100 && a <= 16'h0108) ? v[a[3:0]] : 0;
        endcase
    endfunction
    function automatic scr_pkg::scr_timebase_cfg_t exp_cfg();
        return '{act[0], act[1][3], act[1][2:1], act[1][0],
            {act[5][4:0], act[4], act[3]}, {act[8][3:0], act[7], act[6]}};
    endfunction
    task automatic drain(int extra);
        int n;
        n = 0;
        while (host.cmd_q.size() > 0 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 100) begin
            error_cnt++;
            summarize();
        end
        repeat (extra) @(negedge sys_clk);
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        host.cmd_q.push_back('{a, d, 1'b1, 1'b0});
        if (a == 16'h0000) begin
            ctl = d & 8'hC0;
            if (d[5]) begin
                stg = dflt;
                act = dflt;
                scr = 16'h0000;
                rb_stg = 1'b0;
                rb_act = 1'b0;
            end
        end
        if (a == 16'h0004) rb_stg = d[0];
        if (a == 16'h0005 && d[0]) begin
            act = stg;
            rb_act = rb_stg;
        end
        if (a == 16'h0006) scr[7:0] = d;
        if (a == 16'h0007) scr[15:8] = d;
        if (a >= 16'h0100 && a <= 16'h0108) stg[a[3:0]] = d & msk[a[3:0]];
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] exp);
        int n;
        n = 0;
        host.cmd_q.push_back('{a, 8'h00, 1'b0, 1'b1});
        while (host.rsp_q.size() == 0 && n < 150) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 150) begin
            error_cnt++;
            summarize();
        end
        check($sformatf("read %h", a), 64'(host.rsp_q.pop_front()), 64'(exp));
    endtask
    task automatic strobe();
        wr(16'h0005, 8'h01);
        host.cmd_q.push_back('0);
        rd(16'h0005, 8'h00);
        drain(1);
    endtask
    task automatic read_all();
        @(negedge sys_clk);
        rom_load_status = 1'($random(seed));
        for (int a = 0; a < 16; a++) begin
            if (a != 4) rd(16'(a), exp_rd(16'(a)));
        end
        for (int a = 256; a < 266; a++) rd(16'(a), exp_rd(16'(a)));
    endtask
    task automatic ee_wr(logic [15:0] a, logic [7:0] d);
        @(negedge sys_clk);
        ee_req = '{a, d, 1'b1};
        @(negedge sys_clk);
        ee_req.wr = 1'b0;
        if (a >= 16'h0100 && a <= 16'h0108) stg[a[3:0]] = d & msk[a[3:0]];
    endtask
    // ==================================================================
    // Main sequence
    initial begin
        stg = dflt;
        act = dflt;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        check("cfg", 64'(timebase_cfg), 64'(exp_cfg()));
        check("outs", 64'({serial_out_drive_enable, lsb_first, scratch}), 0);
        read_all();
        foreach (ro[i]) wr(ro[i], 8'($random(seed)));
        read_all();
        wr(16'h0006, 8'($random(seed)));
        wr(16'h0007, 8'($random(seed)));
        drain(1);
        check("scratch", 64'(scratch), 64'(scr));
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 9; i++) wr(16'(256 + i), 8'($random(seed)) & msk[i]);
            read_all();
            strobe();
            check("cfg", 64'(timebase_cfg), 64'(exp_cfg()));
            if (k == 1 || k == 2) begin
                wr(16'h0004, 8'(k == 1));
                strobe();
            end
        end
        ee_wr(16'h0100, 8'h5C);
        ee_wr(16'h0000, 8'hC0);
        strobe();
        check("cfg", 64'(timebase_cfg), 64'(exp_cfg()));
        rd(16'h0000, exp_rd(16'h0000));
        wr(16'h0108, stg[8] | 8'h10);
        strobe();
        drain(2);
        check("restart", 64'(pulses), 64'h1);
        rd(16'h0108, exp_rd(16'h0108));
        wr(16'h0000, 8'hC0);
        drain(1);
        check("drive", 64'({serial_out_drive_enable, lsb_first}), 64'h3);
        wr(16'h0006, 8'($random(seed)));
        wr(16'h0000, 8'hE0);
        drain(2);
        check("scratch", 64'(scratch), 64'(scr));
        check("drive", 64'({serial_out_drive_enable, lsb_first}), 64'h3);
        strobe();
        check("cfg", 64'(timebase_cfg), 64'(exp_cfg()));
        read_all();
        summarize();
    end
endmodule // testbench
